// ---- include/timer_wave_params.svh ----
// Constants for the timer waveform output control block.
// Assumes an 8-bit register port with separate data-space and I/O-space decode.
`ifndef TIMER_WAVE_PARAMS_SVH
`define TIMER_WAVE_PARAMS_SVH

// ============================================================
// Register map
`define WCA_DATA_ADDR 8'h44
`define WCA_IO_OFFSET 8'h20
`define WCA_IO_ADDR (`WCA_DATA_ADDR - `WCA_IO_OFFSET)
`define WCA_RESET 8'h00
`define WCA_WRITE_MASK 8'hf3

// ============================================================
// Field positions
`define OUT_MODE_A_HI 7
`define OUT_MODE_A_LO 6
`define OUT_MODE_B_HI 5
`define OUT_MODE_B_LO 4
`define WAVE_MODE_HI 1
`define WAVE_MODE_LO 0

// ============================================================
// Counter limits
`define COUNT_MAX 8'hff
`define COUNT_BOTTOM 8'h00
`define COUNT_ONE 8'h01

`endif

// ---- include/timer_wave_pkg.sv ----
// Types shared by the timer waveform output control block.
// Assumes the constants header is included where numbers are needed.
`default_nettype none

package timer_wave_pkg;

	// ============================================================
	// Waveform modes, three bits
	typedef enum logic [2:0] {
		mode_normal = 3'b000,
		mode_phase_max = 3'b001,
		mode_match_clear = 3'b010,
		mode_fast_max = 3'b011,
		mode_rsvd_4 = 3'b100,
		mode_phase_cmp = 3'b101,
		mode_rsvd_6 = 3'b110,
		mode_fast_cmp = 3'b111
	} wave_mode_t;

	// Waveform families
	typedef enum logic [1:0] {
		family_plain = 2'b00,
		family_fast = 2'b01,
		family_phase = 2'b10
	} wave_family_t;

	// Output-mode codes
	typedef enum logic [1:0] {
		out_off = 2'b00,
		out_toggle = 2'b01,
		out_clear = 2'b10,
		out_set = 2'b11
	} out_mode_t;

endpackage

`default_nettype wire

// ---- verilog/timer_wave_output.sv ----
// Waveform generation and compare output control of an 8-bit timer.
// Assumes compare values, direction bits and the high mode bit come from
// neighbouring registers, and that count_tick is the prescaled timer clock.
`include "timer_wave_params.svh"
`default_nettype none

module timer_wave_output (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_io_space,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Neighbouring register fields
	input wire logic wave_mode_bit2,
	input wire logic [7:0] compare_value_a,
	input wire logic [7:0] compare_value_b,
	input wire logic dir_a,
	input wire logic dir_b,
	input wire logic port_data_a,
	input wire logic port_data_b,
	// Timer clock
	input wire logic count_tick,
	// Counter state
	output logic [7:0] count_value,
	output logic count_up,
	output logic overflow_flag,
	output timer_wave_pkg::wave_mode_t wave_mode,
	// Pins
	output logic wave_out_a_pin,
	output logic wave_out_a_oe_n,
	output logic wave_out_b_pin,
	output logic wave_out_b_oe_n
);
	import timer_wave_pkg::*;

	// ============================================================
	// Functions

	// Next output level for one channel
	function automatic logic wave_next(
		input wave_family_t fam,
		input out_mode_t om,
		input logic toggle_ok,
		input logic cur,
		input logic match,
		input logic cmp_is_top,
		input logic at_top,
		input logic going_up
	);
		logic v;
		v = cur;
		unique case (fam)
			family_plain: begin
				if (match) begin
					unique case (om)
						out_off: v = cur;
						out_toggle: v = ~cur;
						out_clear: v = 1'b0;
						out_set: v = 1'b1;
					endcase
				end
			end
			family_fast: begin
				if (om == out_toggle) begin
					if (match && toggle_ok)
						v = ~cur;
				end else if (om != out_off) begin
					// BOTTOM action wins, so a compare at TOP is ignored
					if (at_top)
						v = (om == out_clear);
					else if (match && !cmp_is_top)
						v = (om == out_set);
				end
			end
			default: begin
				if (om == out_toggle) begin
					if (match && toggle_ok)
						v = ~cur;
				end else if (om != out_off) begin
					if (cmp_is_top) begin
						if (at_top)
							v = (om == out_clear);
					end else if (match) begin
						v = going_up ? (om == out_set) : (om == out_clear);
					end
				end
			end
		endcase
		return v;
	endfunction

	// ============================================================
	// Register decode
	logic [7:0] control;
	wire reg_hit = reg_io_space ? (reg_addr == `WCA_IO_ADDR)
		: (reg_addr == `WCA_DATA_ADDR);
	wire reg_write = clk_en && reg_wr && reg_hit;
	wire reg_read = clk_en && reg_rd;

	// Control register, reserved bits stay zero
	always_ff @(posedge clk) begin
		if (reset)
			control <= `WCA_RESET;
		else if (reg_write)
			control <= reg_wdata & `WCA_WRITE_MASK;
	end

	// Read data is registered; unmapped reads return zero
	always_ff @(posedge clk) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= reg_hit ? control : 8'h00;
	end

	// ============================================================
	// Mode decode
	wire out_mode_t out_mode_a = out_mode_t'({control[`OUT_MODE_A_HI], control[`OUT_MODE_A_LO]});
	wire out_mode_t out_mode_b = out_mode_t'({control[`OUT_MODE_B_HI], control[`OUT_MODE_B_LO]});
	assign wave_mode = wave_mode_t'({wave_mode_bit2,
		control[`WAVE_MODE_HI:`WAVE_MODE_LO]});

	wave_family_t family;
	logic top_from_cmp;
	logic ovf_at_top;
	// Family, TOP source and overflow point per mode
	always_comb begin
		family = family_plain;
		top_from_cmp = 1'b0;
		ovf_at_top = 1'b0;
		unique case (wave_mode)
			mode_normal: family = family_plain;
			mode_match_clear: top_from_cmp = 1'b1;
			mode_phase_max: family = family_phase;
			mode_phase_cmp: begin
				family = family_phase;
				top_from_cmp = 1'b1;
			end
			mode_fast_max: family = family_fast;
			mode_fast_cmp: begin
				family = family_fast;
				top_from_cmp = 1'b1;
				ovf_at_top = 1'b1;
			end
			mode_rsvd_4: family = family_plain;
			mode_rsvd_6: family = family_plain;
		endcase
	end

	// ============================================================
	// Compare buffering
	logic [7:0] cmp_buf_a;
	logic [7:0] cmp_buf_b;
	wire pwm = (family != family_plain);
	// Non-PWM modes see writes at once; PWM modes see the buffer
	wire [7:0] cmp_a = pwm ? cmp_buf_a : compare_value_a;
	wire [7:0] cmp_b = pwm ? cmp_buf_b : compare_value_b;
	wire [7:0] top = top_from_cmp ? cmp_a : `COUNT_MAX;
	wire at_top = (count_value == top);
	wire at_bottom = (count_value == `COUNT_BOTTOM);
	wire tick = clk_en && count_tick;

	// Buffer loads at TOP for phase PWM, at BOTTOM for fast PWM
	wire buf_load = !pwm
		|| (family == family_phase && at_top)
		|| (family == family_fast && at_bottom);

	always_ff @(posedge clk) begin
		if (reset) begin
			cmp_buf_a <= 8'h00;
			cmp_buf_b <= 8'h00;
		end else if (clk_en && buf_load) begin
			cmp_buf_a <= compare_value_a;
			cmp_buf_b <= compare_value_b;
		end
	end

	// ============================================================
	// Counter
	logic [7:0] next_count;
	logic next_up;
	logic next_ovf;
	always_comb begin
		next_count = count_value + `COUNT_ONE;
		next_up = count_up;
		next_ovf = 1'b0;
		if (family == family_phase) begin
			// Dual slope: TOP and BOTTOM each last one tick
			if (count_up && at_top) begin
				next_count = count_value - `COUNT_ONE;
				next_up = 1'b0;
			end else if (!count_up && at_bottom) begin
				next_count = count_value + `COUNT_ONE;
				next_up = 1'b1;
			end else if (!count_up) begin
				next_count = count_value - `COUNT_ONE;
			end
			next_ovf = !count_up && (count_value == `COUNT_ONE);
		end else begin
			if (at_top)
				next_count = `COUNT_BOTTOM;
			next_up = 1'b1;
			next_ovf = ovf_at_top ? at_top
				: (count_value == `COUNT_MAX);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_value <= `COUNT_BOTTOM;
			count_up <= 1'b1;
		end else if (tick) begin
			count_value <= next_count;
			count_up <= next_up;
		end
	end

	// Overflow pulse marks the tick on which the counter leaves MAX (TOP in mode_fast_cmp), or reaches BOTTOM in phase modes
	always_ff @(posedge clk) begin
		if (reset)
			overflow_flag <= 1'b0;
		else if (clk_en)
			overflow_flag <= tick && next_ovf;
	end

	// ============================================================
	// Waveform outputs
	logic wave_a;
	logic wave_b;
	wire match_a = tick && (count_value == cmp_a);
	wire match_b = tick && (count_value == cmp_b);
	wire top_tick = tick && at_top;
	wire next_wave_a = wave_next(family, out_mode_a, wave_mode_bit2, wave_a, match_a,
		cmp_a == top, top_tick, count_up);
	// Channel B never toggles in PWM, code 01 stays inert
	wire next_wave_b = wave_next(family, out_mode_b, 1'b0, wave_b, match_b,
		cmp_b == top, top_tick, count_up);

	always_ff @(posedge clk) begin
		if (reset) begin
			wave_a <= 1'b0;
			wave_b <= 1'b0;
		end else if (clk_en) begin
			wave_a <= next_wave_a;
			wave_b <= next_wave_b;
		end
	end

	// ============================================================
	// Pin override
	// PWM code 01 on A is disconnected unless bit2 is set
	wire a_disc = pwm && (out_mode_a == out_toggle) && !wave_mode_bit2;
	wire b_disc = pwm && (out_mode_b == out_toggle);
	wire a_conn = (out_mode_a != out_off) && !a_disc;
	wire b_conn = (out_mode_b != out_off) && !b_disc;

	// Waveform replaces the port data only when connected
	assign wave_out_a_pin = a_conn ? wave_a : port_data_a;
	assign wave_out_b_pin = b_conn ? wave_b : port_data_b;
	// The direction bit alone enables the driver
	assign wave_out_a_oe_n = !dir_a;
	assign wave_out_b_oe_n = !dir_b;

endmodule // timer_wave_output

`default_nettype wire

// ---- test/wave_load_model.sv ----
// Model of the circuitry hanging on the two waveform pins.
// Assumes a pull-down on each line while its pin driver is off.
`default_nettype none

module wave_load_model (
	// Pin drivers
	input wire logic pin_a,
	input wire logic oe_a_n,
	input wire logic pin_b,
	input wire logic oe_b_n,
	// Levels seen on the lines
	output logic line_a,
	output logic line_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released line falls to its pull-down, never keeps the last value
	assign line_a = oe_a_n ? 1'h0 : pin_a;
	assign line_b = oe_b_n ? 1'h0 : pin_b;
endmodule // wave_load_model

`default_nettype wire

// ---- test/timer_wave_props.sv ----
// Checker for the timer waveform output control block.
// Assumes it is bound to timer_wave_output and sees only its ports.
`default_nettype none

module timer_wave_props
	import timer_wave_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_io_space,
	input wire logic reg_wr,
	input wire logic reg_rd,
	// Neighbouring register fields
	input wire logic [7:0] compare_value_a,
	input wire logic wave_mode_bit2,
	input wire logic dir_a,
	input wire logic dir_b,
	input wire logic port_data_a,
	input wire logic port_data_b,
	// Timer clock and counter state
	input wire logic count_tick,
	input wire logic [7:0] count_value,
	input wire logic count_up,
	input wire logic overflow_flag,
	input wire wave_mode_t wave_mode,
	// Pins
	input wire logic wave_out_a_pin,
	input wire logic wave_out_a_oe_n,
	input wire logic wave_out_b_pin,
	input wire logic wave_out_b_oe_n
);
	logic [7:0] ctrl;
	logic hit;
	logic tk;
	// ========
	// Shadow of the control register, so pin checks need no internals
	assign hit = reg_addr == (reg_io_space ? 8'h24 : 8'h44);
	assign tk = clk_en && count_tick;
	always_ff @(posedge clk) begin
		if (reset)
			ctrl <= 8'h00;
		else if (clk_en && reg_wr && hit)
			ctrl <= reg_wdata & 8'hf3;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// Wrap to BOTTOM; the overflow pulse is registered on that same edge
	sequence wrap_s;
		count_value == 8'h00 && overflow_flag;
	endsequence
	oe_level_a: assert property (wave_out_a_oe_n == !dir_a && wave_out_b_oe_n == !dir_b)
		else $error("output enable wrong");
	rd_back_a: assert property (clk_en && reg_rd && hit |=> reg_rdata == $past(ctrl))
		else $error("control read wrong");
	rd_miss_a: assert property (clk_en && reg_rd && !hit |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	mode_map_a: assert property (wave_mode == {wave_mode_bit2, ctrl[1:0]})
		else $error("wave mode wrong");
	pin_a_off_a: assert property (ctrl[7:6] == 2'h0 |-> wave_out_a_pin == port_data_a)
		else $error("pin a not port data");
	pin_b_off_a: assert property ((ctrl[5:4] == 2'h0 || (ctrl[5:4] == 2'h1 && wave_mode[0]))
		|-> wave_out_b_pin == port_data_b)
		else $error("pin b not port data");
	norm_step_a: assert property (tk && wave_mode == mode_normal
		|=> count_value == $past(count_value) + 8'h01)
		else $error("normal count step wrong");
	ctc_clear_a: assert property (tk && wave_mode == mode_match_clear
		&& count_value == compare_value_a |=> count_value == 8'h00)
		else $error("match clear missed");
	fast_wrap_a: assert property (tk && wave_mode == mode_fast_max && count_value == 8'hff
		|=> wrap_s)
		else $error("fast wrap wrong");
	phase_turn_a: assert property (tk && wave_mode == mode_phase_max && count_value == 8'hff
		|=> !count_up)
		else $error("no turn at top");
	fast_set_a: assert property (tk && wave_mode == mode_fast_max && count_value == 8'hff
		&& ctrl[7:6] == 2'h2 |=> wave_out_a_pin)
		else $error("no set at bottom");
endmodule // timer_wave_props

bind timer_wave_output timer_wave_props props (.*);

`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the timer waveform output control block.
// Assumes the package is compiled first and the pins feed a load model.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end

module testbench
	import timer_wave_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, reset = 1'h1, clk_en = 1'h1, reg_io_space = 1'h0;
	logic reg_wr = 1'h0, reg_rd = 1'h0, wave_mode_bit2 = 1'h0, count_tick = 1'h0;
	logic dir_a = 1'h1, dir_b = 1'h1, port_data_a = 1'h0, port_data_b = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, compare_value_a = 8'h00;
	logic [7:0] compare_value_b = 8'h00, reg_rdata, count_value;
	logic count_up, overflow_flag, line_a, line_b;
	logic wave_out_a_pin, wave_out_a_oe_n, wave_out_b_pin, wave_out_b_oe_n;
	wave_mode_t wave_mode;
	int fail_count = 0;
	int n_checks = 0;
	// ========
	// Clock, design and load
	always #25 clk = ~clk;
	timer_wave_output uut (.*);
	wave_load_model load (.pin_a(wave_out_a_pin), .oe_a_n(wave_out_a_oe_n),
		.pin_b(wave_out_b_pin), .oe_b_n(wave_out_b_oe_n), .line_a(line_a), .line_b(line_b));
	// Bus strobes last one cycle, driven between edges
	task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
		@(negedge clk);
		{reg_addr, reg_io_space, reg_wdata, reg_wr} = {a, io, d, 1'h1};
		@(negedge clk);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] e);
		@(negedge clk);
		{reg_addr, reg_io_space, reg_rd} = {a, io, 1'h1};
		@(negedge clk);
		reg_rd = 1'h0;
		`CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic tk(input int n);
		@(negedge clk);
		count_tick = 1'h1;
		repeat (n) @(negedge clk);
		count_tick = 1'h0;
	endtask
	task automatic rst;
		reset = 1'h1;
		repeat (4) @(negedge clk);
		reset = 1'h0;
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Whole run is near 1350 cycles, so 4000 means a hang
	initial begin
		#(50 * 4000);
		fail_count++;
		results;
	end
	// ========
	// Tests
	initial begin
		rst;
		rd(8'h44, 1'h0, 8'h00);
		wr(8'h24, 1'h1, 8'hff);
		rd(8'h44, 1'h0, 8'hf3);
		rd(8'h45, 1'h0, 8'h00);
		wr(8'h44, 1'h0, 8'h00);
		port_data_a = 1'h1;
		dir_b = 1'h0;
		#1 `CHK("line_a", 1'h1, line_a)
		`CHK("oe_b", 1'h1, wave_out_b_oe_n)
		{port_data_a, dir_b} = 2'h1;
		rst;
		{compare_value_a, compare_value_b} = {8'h01, 8'h02};
		wr(8'h44, 1'h0, 8'h50);
		tk(3);
		`CHK("pin_a", 1'h1, line_a)
		`CHK("pin_b", 1'h1, line_b)
		wr(8'h44, 1'h0, 8'hb0);
		tk(256);
		`CHK("count", 8'h03, count_value)
		`CHK("pin_a", 1'h0, line_a)
		`CHK("pin_b", 1'h1, line_b)
		// Swap actions so set and clear each move a wave off its old level
		wr(8'h44, 1'h0, 8'he0);
		tk(256);
		`CHK("pin_a", 1'h1, line_a)
		`CHK("pin_b", 1'h0, line_b)
		rst;
		compare_value_a = 8'h03;
		wr(8'h44, 1'h0, 8'h02);
		`CHK("mode", mode_match_clear, wave_mode)
		tk(5);
		`CHK("count", 8'h01, count_value)
		rst;
		{compare_value_a, compare_value_b} = {8'h02, 8'h05};
		wr(8'h44, 1'h0, 8'hb3);
		tk(256);
		`CHK("count", 8'h00, count_value)
		`CHK("ovf", 1'h1, overflow_flag)
		`CHK("pin_a", 1'h1, line_a)
		`CHK("pin_b", 1'h0, line_b)
		tk(6);
		`CHK("pin_a", 1'h0, line_a)
		`CHK("pin_b", 1'h1, line_b)
		rst;
		{compare_value_a, port_data_b} = {8'h04, 1'h1};
		wr(8'h44, 1'h0, 8'h91);
		tk(256);
		`CHK("count", 8'hfe, count_value)
		`CHK("count_up", 1'h0, count_up)
		`CHK("pin_b", 1'h1, line_b)
		tk(251);
		`CHK("pin_a", 1'h1, line_a)
		tk(8);
		`CHK("pin_a", 1'h0, line_a)
		results;
	end
endmodule // testbench

`default_nettype wire
